// ==== dcd_control_decode.v ====
// How it works
// - frequency-select bit picks tuning word zero or one under bit control
// - phase-select bit picks phase offset zero or one under bit control
// - source bit 1: selects, reset and converter power-down come from pins
// - source bit 0: selects, reset and converter power-down come from bits
// - reset bit drives internal reset only while source bit is 0
// - reset bit 1 clears internal registers, output sits at midscale
// - reset bit 0 leaves internal reset inactive
// - clock-gate bit 1 stops the internal master clock
// - stopped clock halts accumulation, output holds its last value
// - clock-gate bit 0 runs the clock and accumulation normally
// - with source bit 0, converter power-down bit 1 powers converter down
// - converter power-down bit 0 keeps the converter active
// - sign-output enable 1 drives the sign output pin
// - sign-output enable 0 leaves sign output pin high impedance
// - control bits are taken on the internal falling master-clock edge; the code samples them on the rising clock_i edge
// - under pin control, select pins choose frequency and phase registers
`timescale 1ns/1ps
`default_nettype none
`include "dcd_consts.vh"
module dcd_control_decode (
  input wire clock_i,
  input wire rst_i,
  input wire word_valid_i,
  input wire [`DCD_WORD_W-1:0] word_i,
  input wire freq_select_pin_i,
  input wire phase_select_pin_i,
  input wire reset_pin_i,
  input wire powerdown_pin_i,
  input wire sign_data_i,
  output reg tuning_word_sel_o,
  output reg phase_offset_sel_o,
  output reg internal_reset_o,
  output reg osc_clock_en_o,
  output reg converter_powerdown_o,
  output reg sign_out_o,
  output reg sign_out_oe_o,
  output wire [`DCD_FIELD_W-1:0] control_bits_o
);
  reg [`DCD_FIELD_W-1:0] ctrl;
  wire [3:0] pins_sync;
  wire freq_reg_select_bit;
  wire phase_reg_select_bit;
  wire control_source_bit;
  wire reset_bit;
  wire clock_gate_bit;
  wire converter_powerdown_bit;
  wire sign_output_enable_bit;
  reg next_freq_reg_select_bit;
  reg next_psel;
  reg next_rst;
  reg next_pd;

  function is_ctrl_write;
    input [`DCD_WORD_W-1:0] w;
    begin
      is_ctrl_write = (w[`DCD_ADDR_HI:`DCD_ADDR_LO] == `DCD_ADDR_CTRL);
    end
  endfunction

  dcd_sync2 #(.W(4)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({freq_select_pin_i, phase_select_pin_i, reset_pin_i, powerdown_pin_i}),
    .sync_o(pins_sync)
  );

  // single rising-edge domain stands in for the falling-edge sample point
  always @(posedge clock_i) begin
    if (rst_i) begin
      ctrl <= `DCD_FIELD_RST;
    end else if (word_valid_i && is_ctrl_write(word_i)) begin
      ctrl <= word_i[`DCD_FIELD_HI:`DCD_FIELD_LO];
    end
  end

  assign freq_reg_select_bit = ctrl[`DCD_FREQ_REG_SELECT_BIT_POS-`DCD_FIELD_LO];
  assign phase_reg_select_bit = ctrl[`DCD_PSEL_POS-`DCD_FIELD_LO];
  assign control_source_bit = ctrl[`DCD_SRC_POS-`DCD_FIELD_LO];
  assign reset_bit = ctrl[`DCD_RST_POS-`DCD_FIELD_LO];
  assign clock_gate_bit = ctrl[`DCD_CLKGATE_POS-`DCD_FIELD_LO];
  assign converter_powerdown_bit = ctrl[`DCD_PWRDN_POS-`DCD_FIELD_LO];
  assign sign_output_enable_bit = ctrl[`DCD_SIGNEN_POS-`DCD_FIELD_LO];
  assign control_bits_o = ctrl;

  always @* begin
    if (control_source_bit) begin
      next_freq_reg_select_bit = pins_sync[3];
      next_psel = pins_sync[2];
      next_rst = pins_sync[1];
      next_pd = pins_sync[0];
    end else begin
      next_freq_reg_select_bit = freq_reg_select_bit;
      next_psel = phase_reg_select_bit;
      next_rst = reset_bit;
      next_pd = converter_powerdown_bit;
    end
  end

  // outputs registered; reset state keeps oscillator halted-free and pin released
  always @(posedge clock_i) begin
    if (rst_i) begin
      tuning_word_sel_o <= 1'b0;
      phase_offset_sel_o <= 1'b0;
      internal_reset_o <= 1'b0;
      osc_clock_en_o <= 1'b1;
      converter_powerdown_o <= 1'b0;
      sign_out_o <= 1'b0;
      sign_out_oe_o <= 1'b0;
    end else begin
      tuning_word_sel_o <= next_freq_reg_select_bit;
      phase_offset_sel_o <= next_psel;
      internal_reset_o <= next_rst;
      // enable low freezes accumulator, so the converter holds its value
      osc_clock_en_o <= ~clock_gate_bit;
      converter_powerdown_o <= next_pd;
      sign_out_o <= sign_data_i;
      sign_out_oe_o <= sign_output_enable_bit;
    end
  end
endmodule
`default_nettype wire

// ==== dcd_consts.vh ====
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH
// control word layout
`define DCD_WORD_W 16
`define DCD_ADDR_HI 15
`define DCD_ADDR_LO 14
`define DCD_ADDR_CTRL 2'h0
`define DCD_FREQ_REG_SELECT_BIT_POS 11
`define DCD_PSEL_POS 10
`define DCD_SRC_POS 9
`define DCD_RST_POS 8
`define DCD_CLKGATE_POS 7
`define DCD_PWRDN_POS 6
`define DCD_SIGNEN_POS 5
`define DCD_FIELD_HI 11
`define DCD_FIELD_LO 5
`define DCD_FIELD_W 7
// all decoded bits clear after reset: bit control, clock running, converter on
`define DCD_FIELD_RST 7'h00
`endif

// ==== dcd_sync2.v ====
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin levels
module dcd_sync2 #(
  parameter W = 2
) (
  input wire clock_i,
  input wire rst_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] stage1;
  always @(posedge clock_i) begin
    if (rst_i) begin
      stage1 <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== dcd_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcd_assertions (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic word_valid_i,
  input wire logic sign_data_i,
  input wire logic tuning_word_sel_o,
  input wire logic internal_reset_o,
  input wire logic osc_clock_en_o,
  input wire logic converter_powerdown_o,
  input wire logic sign_out_o,
  input wire logic sign_out_oe_o,
  input wire logic [15:0] word_i,
  input wire logic [6:0] control_bits_o
);
  wire take = word_valid_i && word_i[15:14] == 2'h0;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence bit_take; take && !word_i[9]; endsequence
  a_bits_store: assert property (take |=> control_bits_o == $past(word_i[11:5]))
    else $error("bits");
  a_freq_bit: assert property (bit_take |=> ##1 tuning_word_sel_o == $past(word_i[11], 2))
    else $error("freq_reg_select_bit");
  a_reset_bit: assert property (bit_take |=> ##1 internal_reset_o == $past(word_i[8], 2))
    else $error("reset");
  a_clock_gate: assert property (take |=> ##1 osc_clock_en_o == !$past(word_i[7], 2))
    else $error("gate");
  a_dac_down: assert property (bit_take |=> ##1 converter_powerdown_o == $past(word_i[6], 2))
    else $error("pdown");
  a_sign_enable: assert property (take |=> ##1 sign_out_oe_o == $past(word_i[5], 2))
    else $error("oe");
  a_sign_copy: assert property (!$past(rst_i) |-> sign_out_o == $past(sign_data_i))
    else $error("sign");
  a_word_refused: assert property (!take |=> $stable(control_bits_o))
    else $error("refused");
endmodule
bind dcd_control_decode dcd_assertions chk (.clock_i, .rst_i, .word_valid_i, .sign_data_i,
  .tuning_word_sel_o, .internal_reset_o, .osc_clock_en_o, .converter_powerdown_o,
  .sign_out_o, .sign_out_oe_o, .word_i, .control_bits_o);
`default_nettype wire

// ==== dcd_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcd_host (
  input wire logic clock_i,
  output logic word_valid_o,
  output logic [15:0] word_o
);
  initial {word_valid_o, word_o} = 17'h0;
  task automatic send(input logic [15:0] w);
    @(posedge clock_i) #1 {word_valid_o, word_o} = {1'b1, w};
    @(posedge clock_i) #1 {word_valid_o, word_o} = {1'b0, ~w};
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_i = 0, rst_i = 1, sd = 0, wv;
  logic [3:0] pin = 0;
  logic [15:0] wd;
  wire fs, ps, ir, ce, pd, so, oe;
  wire [6:0] cb;
  logic [6:0] cb_exp = 7'h00;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) sd <= #1 ~sd;
  dcd_host host (.clock_i(clock_i), .word_valid_o(wv), .word_o(wd));
  dcd_control_decode uut (.clock_i(clock_i), .rst_i(rst_i), .word_valid_i(wv), .word_i(wd),
    .freq_select_pin_i(pin[3]), .phase_select_pin_i(pin[2]), .reset_pin_i(pin[1]),
    .powerdown_pin_i(pin[0]), .sign_data_i(sd), .tuning_word_sel_o(fs),
    .phase_offset_sel_o(ps), .internal_reset_o(ir), .osc_clock_en_o(ce),
    .converter_powerdown_o(pd), .sign_out_o(so), .sign_out_oe_o(oe), .control_bits_o(cb));
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [5:0] e);
    logic s;
    repeat (4) @(posedge clock_i);
    // sign data only moves after the edge, so this is the value taken at it
    s = sd;
    #1 n_checks++;
    if ({fs, ps, ir, ce, pd, oe, so} !== {e, s}) begin
      n_mismatch++;
      $display("wrong value at %0t: %b not %b", $time, {fs, ps, ir, ce, pd, oe, so}, {e, s});
    end
  endtask
  task automatic wr(input logic [15:0] w, input logic [5:0] e);
    host.send(w);
    if (w[15:14] == 2'h0) cb_exp = w[11:5];
    chk(e);
    n_checks++;
    if (cb !== cb_exp) begin
      n_mismatch++;
      $display("wrong value at %0t: stored bits %h not %h", $time, cb, cb_exp);
    end
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    #1 rst_i = 0;
    chk(6'h04);
    wr(16'h0800, 6'h24);
    wr(16'h0400, 6'h14);
    wr(16'h0100, 6'h0C);
    wr(16'h0000, 6'h04);
    wr(16'h0080, 6'h00);
    wr(16'h0040, 6'h06);
    wr(16'h0020, 6'h05);
    wr(16'hCFE0, 6'h05);
    wr(16'h0000, 6'h04);
    pin = 4'hF;
    wr(16'h0200, 6'h3E);
    pin = 4'h0;
    chk(6'h04);
    wr(16'h0F40, 6'h04);
    close_out;
  end
endmodule
`default_nettype wire
